// File: inc/adc_out_pkg.sv
// Purpose: Shared constants and types for the converter output and clock control
// Assumes: ref_clk at 25 MHz; encode clock sampled as an ordinary input
// Notes: The encode-stop count derives from the named time and the clock rate
package adc_out_pkg;
  // Sample word and lane widths, and buffer depth
  localparam int SAMPLE_W = 14;
  localparam int DDR_LINES = 7;
  localparam int FIFO_DEPTH = 32;
  // Output formats; the fourth code of the mode field falls back to full rate
  typedef enum logic [1:0] {
    FMT_FULL = 2'b00,
    FMT_DDR_SE = 2'b01,
    FMT_DDR_DIFF = 2'b10
  } out_fmt_t;
  localparam logic [1:0] FMT_RESET = 2'h0;
  // Driver current codes: 0..6 give 1.75, 2.1, 2.5, 3, 3.5, 4, 4.5 mA
  localparam logic [2:0] DRIVE_DEFAULT = 3'h4;
  localparam logic [2:0] DRIVE_MAX = 3'h6;
  // Stabilizer lock length in encode cycles
  localparam logic [6:0] LOCK_CYCLES = 7'h64;
  // Clock rate and encode-stop detection time
  localparam int REF_CLK_MHZ = 25;
  localparam int ENC_STOP_NS = 2000;
  localparam int ENC_STOP_CYCLES = (ENC_STOP_NS * REF_CLK_MHZ) / 1000;
  // Period slack, in ref_clk cycles, before a frequency change is declared
  localparam logic [7:0] PERIOD_TOL = 8'h01;
endpackage : adc_out_pkg

// File: rtl/sample_fifo.sv
// Purpose: Sample word buffer between the converter core and the output formatter
// Assumes: One clock; valid/ready handshake on both sides
// Notes: Full and empty are exact; a full buffer drops in_ready
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Word storage
  logic [AW-1:0] wr_ptr_reg;  // Next slot to write
  logic [AW-1:0] rd_ptr_reg;  // Next slot to read
  logic [AW:0] count_reg;  // Words held
  logic [AW:0] count_next;  // Words held after this edge
  logic in_ready_reg;  // Room for one more word, registered so the port leaves a flip-flop
  logic push;
  logic pop;

  assign in_ready = in_ready_reg;
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Storage write; no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at DEPTH
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // Occupancy; simultaneous push and pop leave it unchanged
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Ready is worked out from the next count so it drops on the edge that fills
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      in_ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule : sample_fifo

// File: rtl/adc_output_ctrl.sv
// Purpose: Output format selection, DDR multiplexing and duty stabilizer control
// Assumes: Encode clock and strap pins are asynchronous and sampled by ref_clk
// Notes: Encode must be at least one ref_clk cycle per phase to be seen
`timescale 1ns/10ps
module adc_output_ctrl #(
  parameter int FIFO_DEPTH = adc_out_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pins, asynchronous to ref_clk
  input wire logic encode_clock_input,
  input wire logic programming_style_select,
  input wire logic serial_clock_pin,
  input wire logic chip_select_pin,
  // Serially programmed fields
  input wire logic [1:0] output_config_mode_register,
  input wire logic [2:0] drive_current_field,
  input wire logic clock_config_mode_register,
  // Sample words from the converter core
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [adc_out_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic sample_overflow,
  // Output lines
  output logic [adc_out_pkg::SAMPLE_W-1:0] data_out,
  output logic [adc_out_pkg::DDR_LINES-1:0] ddr_bit_pair_line,
  output logic overflow_flag,
  output logic forwarded_output_clock,
  output logic forwarded_output_clock_n,
  // Driver and status
  output logic [1:0] active_format,
  output logic diff_drive_enable,
  output logic [2:0] drive_current_code,
  output logic stabilizer_on,
  output logic stabilizer_locked,
  output logic conversion_stable
);
  localparam int W = adc_out_pkg::SAMPLE_W;

  // Two-stage synchronisers for {encode, strap, clock pin, select pin}
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic enc_prev_reg;  // Encode level one cycle back
  logic enc_rise;
  logic enc_fall;

  // Configuration chosen this cycle
  logic [1:0] fmt_next;
  logic [2:0] drive_next;
  logic dcs_next;
  logic [1:0] fmt_reg;
  logic dcs_reg;

  // Encode period tracking
  logic [7:0] per_cnt_reg;  // ref_clk cycles since last rising edge
  logic [7:0] last_period_reg;  // Length of the previous period
  logic running_reg;  // Encode seen recently
  logic [6:0] lock_cnt_reg;  // Encode cycles since stabilizer restart
  logic locked_reg;
  logic period_jump;
  logic enc_stop;

  // Phase control
  logic half_done_reg;  // Second phase issued in this period
  logic phase_b;

  // Buffered word and its fields
  logic fifo_valid;
  logic [W:0] fifo_data;
  logic pop;
  logic [W-1:0] cur_word_reg;
  logic [adc_out_pkg::DDR_LINES-1:0] even_bits;
  logic [adc_out_pkg::DDR_LINES-1:0] odd_bits;
  logic [adc_out_pkg::DDR_LINES-1:0] new_even;

  // Output registers
  logic [W-1:0] data_out_reg;
  logic [adc_out_pkg::DDR_LINES-1:0] pair_reg;
  logic of_reg;
  logic fclk_reg;
  logic fclk_n_reg;

  // Pin synchronisers; only the second stage is read by logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
      enc_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {encode_clock_input, programming_style_select,
                       serial_clock_pin, chip_select_pin};
      pin_sync_reg <= pin_meta_reg;
      enc_prev_reg <= pin_sync_reg[3];
    end
  end

  assign enc_rise = pin_sync_reg[3] && !enc_prev_reg;
  assign enc_fall = !pin_sync_reg[3] && enc_prev_reg;

  // Mode selection from strap or serial fields
  always_comb begin
    if (pin_sync_reg[2]) begin
      // Parallel mode: no DDR single-ended path exists here
      fmt_next = pin_sync_reg[1] ? 2'(adc_out_pkg::FMT_DDR_DIFF)
                                 : 2'(adc_out_pkg::FMT_FULL);
      drive_next = adc_out_pkg::DRIVE_DEFAULT;
      dcs_next = pin_sync_reg[0];
    end else begin
      // Serial mode; the unused mode code falls back to full rate
      fmt_next = (output_config_mode_register == 2'h3) ? 2'(adc_out_pkg::FMT_FULL)
                                                        : output_config_mode_register;
      // Code seven is not a level; hold the default instead
      drive_next = (drive_current_field > adc_out_pkg::DRIVE_MAX)
                   ? adc_out_pkg::DRIVE_DEFAULT : drive_current_field;
      dcs_next = clock_config_mode_register;
    end
  end

  // Registered configuration and driver controls
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fmt_reg <= adc_out_pkg::FMT_RESET;
      dcs_reg <= 1'b0;
      diff_drive_enable <= 1'b0;
      drive_current_code <= adc_out_pkg::DRIVE_DEFAULT;
    end else begin
      fmt_reg <= fmt_next;
      dcs_reg <= dcs_next;
      // Follows the registered format so it moves together with active_format
      diff_drive_enable <= (fmt_reg == 2'(adc_out_pkg::FMT_DDR_DIFF));
      drive_current_code <= drive_next;
    end
  end

  // A lost encode or a period jump restarts the lock count
  assign enc_stop = (per_cnt_reg == 8'(adc_out_pkg::ENC_STOP_CYCLES));
  assign period_jump = enc_rise &&
                       ((per_cnt_reg > last_period_reg + adc_out_pkg::PERIOD_TOL) ||
                        (per_cnt_reg + adc_out_pkg::PERIOD_TOL < last_period_reg));

  // Period measurement; counter saturates at the stop threshold
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      per_cnt_reg <= 8'h00;
      last_period_reg <= 8'h00;
      running_reg <= 1'b0;
    end else if (enc_rise) begin
      per_cnt_reg <= 8'h01;
      last_period_reg <= per_cnt_reg;
      running_reg <= 1'b1;
    end else if (enc_stop) begin
      running_reg <= 1'b0;
    end else begin
      per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end

  // Stabilizer lock: one hundred steady encode cycles after any restart
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_cnt_reg <= 7'h00;
      locked_reg <= 1'b0;
    end else if (!dcs_reg || enc_stop || period_jump || !running_reg) begin
      lock_cnt_reg <= 7'h00;
      locked_reg <= 1'b0;
    end else if (enc_rise && !locked_reg) begin
      lock_cnt_reg <= lock_cnt_reg + 7'h01;
      locked_reg <= (lock_cnt_reg + 7'h01 == adc_out_pkg::LOCK_CYCLES);
    end
  end

  // Second phase: mid-period when stabilized, else the encode falling edge.
  // The midpoint ignores input duty, so 30-70% input still gives 50% out.
  always_comb begin
    if (dcs_reg && locked_reg) begin
      phase_b = !half_done_reg && !enc_rise &&
                (per_cnt_reg == {1'b0, last_period_reg[7:1]});
    end else begin
      phase_b = enc_fall && !half_done_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      half_done_reg <= 1'b1;
    end else if (enc_rise) begin
      half_done_reg <= 1'b0;
    end else if (phase_b) begin
      half_done_reg <= 1'b1;
    end
  end

  // Buffer between the core and the pins; drained once per encode period
  assign pop = enc_rise;
  sample_fifo #(
    .WIDTH(W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .reset(reset),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_overflow, sample_data}),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Split words into even and odd lanes
  genvar gi;
  generate
    for (gi = 0; gi < adc_out_pkg::DDR_LINES; gi++) begin : g_lane
      assign even_bits[gi] = cur_word_reg[2*gi];
      assign odd_bits[gi] = cur_word_reg[2*gi+1];
      assign new_even[gi] = fifo_data[2*gi];
    end
  endgenerate

  // Current word; an empty buffer repeats the last word rather than stalling pins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cur_word_reg <= '0;
      of_reg <= 1'b0;
    end else if (enc_rise && fifo_valid) begin
      cur_word_reg <= fifo_data[W-1:0];
      of_reg <= fifo_data[W];
    end
  end

  // Data lines: phase A changes data with the clock falling.
  // Lines of the unused format clear at once, not at the next encode,
  // so a format change never leaves stale bits on idle pins.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_out_reg <= '0;
      pair_reg <= '0;
    end else if (fmt_reg == 2'(adc_out_pkg::FMT_FULL)) begin
      pair_reg <= '0;
      if (enc_rise) begin
        data_out_reg <= fifo_valid ? fifo_data[W-1:0] : cur_word_reg;
      end
    end else begin
      data_out_reg <= '0;  // Unused full-rate lines held low
      if (enc_rise) begin
        pair_reg <= fifo_valid ? new_even : even_bits;
      end else if (phase_b) begin
        pair_reg <= odd_bits;
      end
    end
  end

  // Forwarded clock pair: low from phase A, high from phase B.
  // Idles high after reset so the very first word also lands on a falling edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fclk_reg <= 1'b1;
      fclk_n_reg <= 1'b0;
    end else if (enc_rise) begin
      fclk_reg <= 1'b0;
      fclk_n_reg <= 1'b1;
    end else if (phase_b) begin
      fclk_reg <= 1'b1;
      fclk_n_reg <= 1'b0;
    end
  end

  // Status outputs; host should not trust samples before lock
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_format <= adc_out_pkg::FMT_RESET;
      stabilizer_on <= 1'b0;
      stabilizer_locked <= 1'b0;
      conversion_stable <= 1'b0;
    end else begin
      active_format <= fmt_reg;
      stabilizer_on <= dcs_reg;
      stabilizer_locked <= locked_reg;
      conversion_stable <= running_reg && (!dcs_reg || locked_reg);
    end
  end

  assign data_out = data_out_reg;
  assign ddr_bit_pair_line = pair_reg;
  assign overflow_flag = of_reg;
  assign forwarded_output_clock = fclk_reg;
  assign forwarded_output_clock_n = fclk_n_reg;
endmodule : adc_output_ctrl

// File: tb/adc_output_ctrl_properties.sv
// Purpose: Port-level properties of the output and clock control
// Assumes: Pins held eight cycles have settled through the synchronizers
// Notes: The lock bound allows a few cycles of slack for sync latency
`timescale 1ns/10ps
module adc_output_ctrl_properties (
  // Clock and reset
  input logic ref_clk,
  input logic reset,
  // Pins and fields
  input logic programming_style_select,
  input logic serial_clock_pin,
  input logic chip_select_pin,
  input logic [1:0] output_config_mode_register,
  input logic [2:0] drive_current_field,
  // Outputs
  input logic [adc_out_pkg::SAMPLE_W-1:0] data_out,
  input logic [adc_out_pkg::DDR_LINES-1:0] ddr_bit_pair_line,
  input logic forwarded_output_clock,
  input logic forwarded_output_clock_n,
  input logic [1:0] active_format,
  input logic diff_drive_enable,
  input logic [2:0] drive_current_code,
  input logic stabilizer_on,
  input logic stabilizer_locked,
  input logic conversion_stable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [7:0] fall_cnt_reg; // Output periods seen while the stabilizer runs
  // Counts only up; a stop inside the run can only make the design later
  always_ff @(posedge ref_clk) begin
    if (reset || !stabilizer_on) begin
      fall_cnt_reg <= 8'h00;
    end else if ($fell(forwarded_output_clock) && fall_cnt_reg != 8'hff) begin
      fall_cnt_reg <= fall_cnt_reg + 8'h01;
    end
  end
  // Pins or fields left alone long enough to pass the synchronizers
  sequence par_held;
    (programming_style_select && $stable(serial_clock_pin) && $stable(chip_select_pin))[*8];
  endsequence
  sequence ser_held;
    (!programming_style_select && $stable(output_config_mode_register)
      && $stable(drive_current_field))[*8];
  endsequence
  AST_CLK_PAIR: assert property (forwarded_output_clock_n != forwarded_output_clock)
    else $error("forwarded clock pair not complementary");
  AST_FULL_LANES: assert property (active_format == 2'h0 && $stable(active_format)
    |-> ddr_bit_pair_line == '0) else $error("lanes active in full rate");
  AST_DDR_IDLE: assert property (active_format != 2'h0 && $stable(active_format)
    |-> data_out == '0) else $error("full-rate lines active in ddr");
  AST_DIFF_DRIVE: assert property ($stable(active_format)
    |-> diff_drive_enable == (active_format == adc_out_pkg::FMT_DDR_DIFF))
    else $error("differential driver enable wrong");
  AST_SER_FMT: assert property (ser_held |-> active_format ==
    ((output_config_mode_register == 2'h3) ? 2'h0 : output_config_mode_register))
    else $error("serial format wrong");
  AST_SER_DRIVE: assert property (ser_held |-> drive_current_code ==
    ((drive_current_field == 3'h7) ? adc_out_pkg::DRIVE_DEFAULT : drive_current_field))
    else $error("drive code wrong");
  AST_PAR_FMT: assert property (par_held |-> drive_current_code == 3'h4
    && active_format == (serial_clock_pin ? 2'h2 : 2'h0)) else $error("parallel format wrong");
  AST_PAR_STAB: assert property (par_held |-> stabilizer_on == chip_select_pin)
    else $error("parallel stabilizer wrong");
  AST_LOCK_COUNT: assert property ($rose(stabilizer_locked) |-> fall_cnt_reg >= 8'h60)
    else $error("lock too early");
  AST_STABLE_LOCK: assert property (conversion_stable && stabilizer_on && $past(stabilizer_on)
    |-> ##[0:1] stabilizer_locked) else $error("stable before lock");
  AST_FULL_EDGE: assert property (active_format == 2'h0 && $stable(active_format)
    && $changed(data_out) |-> $fell(forwarded_output_clock))
    else $error("full-rate data off the falling clock");
endmodule : adc_output_ctrl_properties

// File: tb/sample_receiver_model.sv
// Purpose: Receiving logic that rebuilds words from the output link
// Assumes: Format known to it from the bench, as a board would fix it
// Notes: Captures on the rising forwarded clock in every format
`timescale 1ns/10ps
module sample_receiver_model (
  // Clock and reset
  input logic ref_clk,
  input logic reset,
  // Link
  input logic ddr_mode,
  input logic [13:0] data_out,
  input logic [6:0] ddr_bit_pair_line,
  input logic overflow_flag,
  input logic forwarded_output_clock,
  // Rebuilt words
  output logic rx_valid,
  output logic [14:0] rx_word
);
  logic fclk_reg; // Clock level at the previous edge
  logic [6:0] even_reg; // Lanes from the low phase
  // Keep the low-phase lanes until the clock rises
  always_ff @(posedge ref_clk) begin
    fclk_reg <= reset ? 1'b1 : forwarded_output_clock; // Link clock idles high
    if (!forwarded_output_clock) begin
      even_reg <= ddr_bit_pair_line;
    end
  end
  // A rise closes a word; full-rate data has been stable since the fall
  always_ff @(posedge ref_clk) begin
    rx_valid <= !reset && !fclk_reg && forwarded_output_clock;
    for (int i = 0; i < 7; i++) begin
      rx_word[2*i] <= ddr_mode ? even_reg[i] : data_out[2*i];
      rx_word[2*i+1] <= ddr_mode ? ddr_bit_pair_line[i] : data_out[2*i+1];
    end
    rx_word[14] <= overflow_flag;
  end
endmodule : sample_receiver_model

// File: tb/adc_output_ctrl_tb.sv
// Purpose: Self-checking bench for the output and clock control
// Assumes: Encode runs 320 ns periods inside bursts and the lock runs, still otherwise
// Notes: Expected words and settings come from the bench model below
`timescale 1ns/10ps
module adc_output_ctrl_tb;
  logic ref_clk = 1'b0, reset = 1'b1, encode_clock_input = 1'b0;
  logic programming_style_select = 1'b0, serial_clock_pin = 1'b0, chip_select_pin = 1'b0;
  logic clock_config_mode_register = 1'b0, sample_valid = 1'b0, sample_overflow = 1'b0;
  logic [1:0] output_config_mode_register = 2'h0, active_format;
  logic [2:0] drive_current_field = 3'h0, drive_current_code;
  logic [13:0] sample_data = 14'h0000, data_out;
  logic [6:0] ddr_bit_pair_line;
  logic sample_ready, overflow_flag, forwarded_output_clock, forwarded_output_clock_n;
  logic diff_drive_enable, stabilizer_on, stabilizer_locked, conversion_stable;
  logic ddr_mode = 1'b0, rx_valid, rx_on = 1'b0;
  logic [14:0] rx_word;
  logic [14:0] exp_q[$]; // Words owed to the receiver
  logic [31:0] seed = 32'hc6ea5ba9;
  int err_total = 0, total_checks = 0, cycles = 0;
  int hi_run = 0, hi_len = 0; // Forwarded clock high phase, running and last complete
  adc_output_ctrl adc_output_ctrl_i (.*);
  sample_receiver_model sample_receiver_model_i (.*);
  always #20 ref_clk = ~ref_clk;
  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic check_val(string what, logic [14:0] exp, logic [14:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check_val
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Length of the last complete high phase of the forwarded clock
  always @(posedge ref_clk) begin
    if (forwarded_output_clock === 1'b1) begin
      hi_run++;
    end else if (hi_run != 0) begin
      hi_len = hi_run;
      hi_run = 0;
    end
  end
  // Every rebuilt word must be the next one sent
  always @(posedge ref_clk) begin
    if (rx_on && rx_valid === 1'b1) begin
      check_val("word", (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7fff, rx_word);
    end
  end
  // Set pins and fields, wait out the synchronizers, compare with the model
  task automatic cfg(logic par, logic sck, logic cs, logic [1:0] m, logic [2:0] d, logic st);
    logic [1:0] f;
    f = par ? (sck ? 2'h2 : 2'h0) : ((m == 2'h3) ? 2'h0 : m);
    programming_style_select <= par;
    serial_clock_pin <= sck;
    chip_select_pin <= cs;
    output_config_mode_register <= m;
    drive_current_field <= d;
    clock_config_mode_register <= st;
    ddr_mode <= (f != 2'h0);
    repeat (10) @(posedge ref_clk);
    check_val("format", 15'(f), 15'(active_format));
    check_val("diff", 15'(f == 2'h2), 15'(diff_drive_enable));
    check_val("drive", (par || d == 3'h7) ? 15'h4 : 15'(d), 15'(drive_current_code));
    check_val("stab", 15'(par ? cs : st), 15'(stabilizer_on));
  endtask : cfg
  // Encode pulses of eight ref_clk cycles, hi of them high
  task automatic run_enc(int n, int hi = 4);
    repeat (n) begin
      encode_clock_input <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      encode_clock_input <= 1'b0;
      repeat (8 - hi) @(posedge ref_clk);
    end
  endtask : run_enc
  // Load n words with encode still, then send them; a full buffer refuses more
  task automatic burst(int n);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      sample_valid <= 1'b1;
      {sample_overflow, sample_data} <= seed[14:0];
      do @(posedge ref_clk); while (sample_ready !== 1'b1);
      exp_q.push_back(seed[14:0]);
    end
    sample_valid <= 1'b0; // Drop at once, or the last word is taken again
    repeat (4) @(posedge ref_clk);
    if (n == 32) begin
      check_val("ready", 15'h0, 15'(sample_ready));
    end
    rx_on = 1'b1;
    run_enc(n);
    repeat (10) @(posedge ref_clk);
    rx_on = 1'b0;
    check_val("left", 15'h0, 15'(exp_q.size()));
  endtask : burst
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    for (int d = 0; d < 8; d++) begin
      cfg(1'b0, 1'b0, 1'b0, 2'h0, 3'(d), 1'b0);
    end
    for (int m = 0; m < 4; m++) begin
      cfg(1'b0, 1'b0, 1'b0, 2'(m), 3'h2, 1'b0);
      burst(1);
    end
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, i[0], i[1], 2'h1, 3'h0, 1'b0);
      burst(6);
    end
    cfg(1'b0, 1'b0, 1'b0, 2'h1, 3'h4, 1'b1);
    run_enc(90);
    check_val("locked", 15'h0, 15'(stabilizer_locked));
    run_enc(20);
    check_val("locked", 15'h1, 15'(stabilizer_locked));
    check_val("stable", 15'h1, 15'(conversion_stable));
    // Same period, 37.5% input duty: lock holds and the output stays at half period
    run_enc(4, 3);
    check_val("locked", 15'h1, 15'(stabilizer_locked));
    check_val("duty", 15'h4, 15'(hi_len));
    burst(6);
    // Stabilizer off again for the 32-word full-rate run
    cfg(1'b0, 1'b0, 1'b0, 2'h0, 3'h4, 1'b0);
    burst(32);
    report_and_stop();
  end
endmodule : adc_output_ctrl_tb
bind adc_output_ctrl adc_output_ctrl_properties adc_output_ctrl_properties_i (.*);
